// file: bridge_regs_pkg.sv
package bridge_regs_pkg;

   // Configuration dword offsets within function 0
   localparam logic [7:0] ident_offset = 8'h00;
   localparam logic [7:0] status_command_offset = 8'h04;

   // Arbitrary neutral identity codes
   localparam logic [15:0] bridge_device_code = 16'h0b01;
   localparam logic [15:0] maker_code = 16'h0a5a;

   localparam logic [31:0] status_command_reset = 32'h0230_0000;

   // Bit positions
   localparam int parity_error_seen_bit = 31;
   localparam int system_error_signaled_bit = 30;
   localparam int master_abort_received_bit = 29;
   localparam int target_abort_received_bit = 28;
   localparam int target_abort_signaled_bit = 27;
   localparam int system_error_report_en_bit = 8;
   localparam int parity_response_bit_pos = 6;
   localparam int write_invalidate_en_bit = 4;
   localparam int special_cycle_bit = 3;
   localparam int secondary_master_en_bit = 2;
   localparam int memory_space_en_bit = 1;
   localparam int io_space_en_bit = 0;

   // Read-only fixed field 26:20 (bits 26:21 default plus capability bit 20)
   localparam logic [31:0] fixed_ro_mask = 32'h07f0_0000;
   localparam logic [31:0] writable_mask = 32'h0000_0157;

   // Configuration access from the tunnel's config decoder
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] offset;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } cfg_req_t;

   // Error events from the bridge datapath, one-cycle pulses
   typedef struct packed {
      logic system_error_detected;
      logic nonexistent_address_error_rx;
      logic other_error_rx;
      logic target_abort_sent;
   } err_events_t;

   // Enables driven to the bridge datapath
   typedef struct packed {
      logic flood_sync;
      logic secondary_master_en;
      logic memory_space_en;
      logic io_space_en;
      logic hot_plug_mem_access_en;
      logic hot_plug_cfg_access_en;
   } bridge_ctrl_t;

endpackage : bridge_regs_pkg

// file: bridge_status_command_regs.sv
`timescale 1ns/1ps
// Functional notes
// - One independent copy per bridge, function 0
// - Offset zero reads device and maker codes
// - Status/command resets to 0230_0000
// - Top parity bit reads zero always
// - System error sets flag; write one clears
// - System error flag needs report enable
// - No sync flooding when report disabled
// - Nonexistent-address response sets master abort flag
// - Other error response sets target abort flag
// - Returned error sets signaled target abort
// - Error flags cleared by power-good reset, not warm reset
// - Bits 26:21 read fixed defaults
// - Capability bit 20 reads one
// - Parity response bit is plain storage
// - Write-invalidate enable is plain storage
// - Special cycle bit reads zero
// - Secondary mastering needs master enable
// - Memory enable gates memory and hot-plug BAR
// - Hot-plug config port ignores memory enable
// - IO space access needs IO enable
// - Write one clears, zero keeps
// - Unmapped offsets read zero, ignore writes
module bridge_status_command_regs (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic power_good_reset_i,
   input wire bridge_regs_pkg::cfg_req_t cfg_req_i,
   input wire bridge_regs_pkg::err_events_t err_events_i,
   output logic cfg_ack_o,
   output logic [31:0] cfg_rdata_o,
   output bridge_regs_pkg::bridge_ctrl_t ctrl_o
);

   // Warm reset clears enables; power-good reset clears everything
   typedef struct packed {
      logic [3:0] err_flags;
      logic system_error_report_en;
      logic parity_response_bit;
      logic write_invalidate_en;
      logic secondary_master_en;
      logic memory_space_en;
      logic io_space_en;
      logic ack;
      logic [31:0] rdata;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic [31:0] status_word;

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   always_comb begin
      status_word = bridge_regs_pkg::status_command_reset & bridge_regs_pkg::fixed_ro_mask;
      status_word[bridge_regs_pkg::parity_error_seen_bit] = 1'b0;
      status_word[30:27] = state_reg.err_flags;
      status_word[bridge_regs_pkg::system_error_report_en_bit] = state_reg.system_error_report_en;
      status_word[bridge_regs_pkg::parity_response_bit_pos] = state_reg.parity_response_bit;
      status_word[bridge_regs_pkg::write_invalidate_en_bit] = state_reg.write_invalidate_en;
      status_word[bridge_regs_pkg::special_cycle_bit] = 1'b0;
      status_word[bridge_regs_pkg::secondary_master_en_bit] = state_reg.secondary_master_en;
      status_word[bridge_regs_pkg::memory_space_en_bit] = state_reg.memory_space_en;
      status_word[bridge_regs_pkg::io_space_en_bit] = state_reg.io_space_en;
   end

   always_comb begin
      logic [31:0] wmask;
      logic [31:0] wr;
      logic [3:0] set_ev;
      logic [3:0] clr;
      logic sc_write;
      wmask = lane_mask(cfg_req_i.byte_en);
      wr = cfg_req_i.wdata & wmask;
      sc_write = cfg_req_i.valid && cfg_req_i.write && (cfg_req_i.offset == bridge_regs_pkg::status_command_offset);
      state_next = state_reg;
      // Hardware events
      set_ev[3] = err_events_i.system_error_detected && state_reg.system_error_report_en;
      set_ev[2] = err_events_i.nonexistent_address_error_rx;
      set_ev[1] = err_events_i.other_error_rx;
      set_ev[0] = err_events_i.target_abort_sent;
      clr = sc_write ? wr[30:27] : 4'h0;
      // A set in the same cycle as a clear wins
      state_next.err_flags = (state_reg.err_flags & ~clr) | set_ev;
      if (sc_write) begin
         if (wmask[8]) begin
            state_next.system_error_report_en = wr[bridge_regs_pkg::system_error_report_en_bit];
         end
         if (wmask[0]) begin
            state_next.parity_response_bit = wr[bridge_regs_pkg::parity_response_bit_pos];
            state_next.write_invalidate_en = wr[bridge_regs_pkg::write_invalidate_en_bit];
            state_next.secondary_master_en = wr[bridge_regs_pkg::secondary_master_en_bit];
            state_next.memory_space_en = wr[bridge_regs_pkg::memory_space_en_bit];
            state_next.io_space_en = wr[bridge_regs_pkg::io_space_en_bit];
         end
      end
      state_next.ack = cfg_req_i.valid;
      state_next.rdata = 32'h0000_0000;
      if (cfg_req_i.valid && !cfg_req_i.write) begin
         if (cfg_req_i.offset == bridge_regs_pkg::ident_offset) begin
            state_next.rdata = {bridge_regs_pkg::bridge_device_code, bridge_regs_pkg::maker_code};
         end else if (cfg_req_i.offset == bridge_regs_pkg::status_command_offset) begin
            state_next.rdata = status_word;
         end else begin
            state_next.rdata = 32'h0000_0000;
         end
      end
   end

   // Error flags survive warm reset; only power-good clears them
   always_ff @(posedge clk_sys_i) begin
      if (power_good_reset_i) begin
         state_reg <= '0;
      end else if (sys_rst_i) begin
         state_reg <= '0;
         state_reg.err_flags <= state_reg.err_flags;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cfg_ack_o = state_reg.ack;
   assign cfg_rdata_o = state_reg.rdata;

   always_comb begin
      ctrl_o.flood_sync = err_events_i.system_error_detected && state_reg.system_error_report_en;
      ctrl_o.secondary_master_en = state_reg.secondary_master_en;
      ctrl_o.memory_space_en = state_reg.memory_space_en;
      ctrl_o.hot_plug_mem_access_en = state_reg.memory_space_en;
      ctrl_o.hot_plug_cfg_access_en = 1'b1;
      ctrl_o.io_space_en = state_reg.io_space_en;
   end

endmodule : bridge_status_command_regs

// file: bridge_regs_checker.sv
`timescale 1ns/1ps
module bridge_regs_checker (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic power_good_reset_i,
   input wire bridge_regs_pkg::cfg_req_t cfg_req_i,
   input wire bridge_regs_pkg::err_events_t err_events_i,
   input wire logic cfg_ack_o,
   input wire logic [31:0] cfg_rdata_o,
   input wire bridge_regs_pkg::bridge_ctrl_t ctrl_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i || power_good_reset_i);
   ack_follow_a: assert property (cfg_req_i.valid |=> cfg_ack_o) else $error("ack missing");
   ack_spurious_a: assert property (!cfg_req_i.valid |=> !cfg_ack_o) else $error("ack without request");
   top_zero_a: assert property (cfg_ack_o |-> !cfg_rdata_o[31]) else $error("parity flag set");
   fixed_fields_a: assert property (cfg_ack_o && $past(cfg_req_i.offset) == 8'h04 && !$past(cfg_req_i.write)
      |-> cfg_rdata_o[26:20] == 7'h23 && !cfg_rdata_o[3]) else $error("fixed field wrong");
   ident_read_a: assert property (cfg_ack_o && $past(cfg_req_i.offset) == 8'h00 && !$past(cfg_req_i.write)
      |-> cfg_rdata_o == {bridge_regs_pkg::bridge_device_code, bridge_regs_pkg::maker_code})
      else $error("ident wrong");
   unmapped_zero_a: assert property (cfg_ack_o && $past(cfg_req_i.offset) > 8'h04 |-> cfg_rdata_o == 32'h0)
      else $error("unmapped read nonzero");
   flood_gate_a: assert property (ctrl_o.flood_sync |-> err_events_i.system_error_detected)
      else $error("flood without error");
   hp_mem_a: assert property (ctrl_o.hot_plug_mem_access_en == ctrl_o.memory_space_en)
      else $error("hot-plug memory gate wrong");
   hp_cfg_a: assert property (ctrl_o.hot_plug_cfg_access_en) else $error("hot-plug port blocked");
endmodule : bridge_regs_checker
bind bridge_status_command_regs bridge_regs_checker checker_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
   .power_good_reset_i(power_good_reset_i), .cfg_req_i(cfg_req_i), .err_events_i(err_events_i),
   .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .ctrl_o(ctrl_o));

// file: test_bridge_status_command_regs.sv
`timescale 1ns/1ps
module test_bridge_status_command_regs;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic power_good_reset_i = 1'b1;
   bridge_regs_pkg::cfg_req_t cfg_req_i = '0;
   bridge_regs_pkg::err_events_t err_events_i = '0;
   logic cfg_ack_o;
   logic [31:0] cfg_rdata_o;
   bridge_regs_pkg::bridge_ctrl_t ctrl_o;
   logic [31:0] exp_reg, rd, wd;
   logic [3:0] be;
   int err_total = 0;
   int check_count = 0;
   bridge_status_command_regs dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .power_good_reset_i(power_good_reset_i), .cfg_req_i(cfg_req_i), .err_events_i(err_events_i),
      .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .ctrl_o(ctrl_o));
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic wrap_up();
      if (err_total == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic chk(string name, logic [31:0] e, logic [31:0] s);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, e, s);
      end
   endtask : chk
   task automatic acc(logic w, logic [7:0] off, logic [3:0] b, logic [31:0] d);
      int i;
      @(negedge clk_sys_i);
      cfg_req_i = '{1'b1, w, off, b, d};
      @(negedge clk_sys_i);
      cfg_req_i.valid = 1'b0;
      for (i = 0; i < 4 && cfg_ack_o !== 1'b1; i++) @(negedge clk_sys_i);
      if (i == 4) begin
         err_total++;
         wrap_up();
      end
      rd = cfg_rdata_o;
   endtask : acc
   function automatic logic [31:0] wr_model(logic [31:0] o, logic [31:0] d, logic [3:0] b);
      if (b[0]) o[7:0] = (o[7:0] & ~8'h57) | (d[7:0] & 8'h57);
      if (b[1]) o[8] = d[8];
      if (b[3]) o[30:27] = o[30:27] & ~d[30:27];
      return o;
   endfunction : wr_model
   task automatic pulse(logic [3:0] ev);
      @(negedge clk_sys_i);
      err_events_i = ev;
      #1;
      chk("flood_sync", {31'h0, ev[3] & exp_reg[8]}, {31'h0, ctrl_o.flood_sync});
      if (ev[3] && exp_reg[8]) exp_reg[30] = 1'b1;
      exp_reg[29:27] = exp_reg[29:27] | ev[2:0];
      @(negedge clk_sys_i);
      err_events_i = '0;
   endtask : pulse
   task automatic rst(logic pg);
      @(negedge clk_sys_i);
      {sys_rst_i, power_good_reset_i} = {~pg, pg};
      repeat (2) @(negedge clk_sys_i);
      {sys_rst_i, power_good_reset_i} = 2'b00;
      exp_reg = (pg ? 32'h0 : exp_reg & 32'h7800_0000) | bridge_regs_pkg::status_command_reset;
      acc(1'b0, 8'h04, 4'hf, 32'h0);
      chk("status after reset", exp_reg, rd);
   endtask : rst
   initial begin
      void'($urandom(41114));
      repeat (2) @(negedge clk_sys_i);
      {sys_rst_i, power_good_reset_i} = 2'b00;
      exp_reg = bridge_regs_pkg::status_command_reset;
      acc(1'b1, 8'h00, 4'hf, 32'hffff_ffff);
      acc(1'b0, 8'h00, 4'hf, 32'h0);
      chk("ident", {bridge_regs_pkg::bridge_device_code, bridge_regs_pkg::maker_code}, rd);
      acc(1'b0, 8'h04, 4'hf, 32'h0);
      chk("status reset", exp_reg, rd);
      acc(1'b1, 8'h08, 4'hf, 32'hffff_ffff);
      acc(1'b0, 8'h08, 4'hf, 32'h0);
      chk("unmapped", 32'h0, rd);
      repeat (40) begin
         wd = $urandom;
         be = 4'($urandom);
         acc(1'b1, 8'h04, be, wd);
         exp_reg = wr_model(exp_reg, wd, be);
         pulse(4'($urandom));
         acc(1'b0, 8'h04, 4'hf, 32'h0);
         chk("status", exp_reg, rd);
         chk("ctrl", {27'h0, exp_reg[2:0], exp_reg[1], 1'b1}, {27'h0, ctrl_o[4:0]});
      end
      acc(1'b1, 8'h04, 4'h2, 32'h0000_0100);
      exp_reg[8] = 1'b1;
      pulse(4'hf);
      rst(1'b0);
      rst(1'b1);
      wrap_up();
   end
endmodule : test_bridge_status_command_regs
